// ==== verilog/dpsel_defines.vh ====
`ifndef DPSEL_DEFINES_VH
`define DPSEL_DEFINES_VH

// ***********************************************
// pointer geometry
// ***********************************************
`define DPSEL_PTR_W 16
`define DPSEL_PTR_RESET 16'h0000

// ***********************************************
// special function register map (core side)
// ***********************************************
`define DPSEL_SFR_CTRL_ADDR 8'hA2
`define DPSEL_SEL_BIT 0
`define DPSEL_CTRL_RESET 8'h00

// ***********************************************
// avalon register indices, byte address = 4 * index
// ***********************************************
`define DPSEL_IDX_PTR_ZERO 10'h000
`define DPSEL_IDX_PTR_ONE 10'h001
`define DPSEL_IDX_PTR_ACTIVE 10'h002
`define DPSEL_IDX_STATUS 10'h003
`define DPSEL_IDX_CTRL 10'h0A2

// ***********************************************
// status register fields
// ***********************************************
`define DPSEL_STAT_SEL_BIT 0
`define DPSEL_STAT_MOVE_BIT 1

`endif

// ==== verilog/dpsel_ptr_bank.v ====
`include "dpsel_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// ***********************************************
// two pointer words, one write port, registered reads
// ***********************************************
module dpsel_ptr_bank #(
    parameter PTR_W = `DPSEL_PTR_W
) (
    // clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // write port
    input wire wr_en_in,
    input wire wr_idx_in,
    input wire [PTR_W-1:0] wr_data_in,
    // read data
    output reg [PTR_W-1:0] ptr_zero_out,
    output reg [PTR_W-1:0] ptr_one_out
);

    // each word changes only when its own index is written
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ptr_zero_out <= `DPSEL_PTR_RESET;
            ptr_one_out <= `DPSEL_PTR_RESET;
        end else if (wr_en_in) begin
            if (wr_idx_in) begin
                ptr_one_out <= wr_data_in;
            end else begin
                ptr_zero_out <= wr_data_in;
            end
        end
    end

endmodule // dpsel_ptr_bank

`default_nettype wire

// ==== verilog/dpsel_top.v ====
// Notes on behaviour
// - two independent sixteen-bit external data pointers
// - select bit zero: clear zero, set one
// - external data address from active pointer
// - select control register at sfr A2
// - reset clears select bit, pointer zero
// - reserved control bits read value undefined
// - increment of control register toggles select
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "dpsel_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module dpsel_top #(
    parameter PTR_W = `DPSEL_PTR_W
) (
    // clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // avalon-mm slave
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // core pointer operations
    input wire ptr_load_in,
    input wire [PTR_W-1:0] ptr_load_data_in,
    input wire ptr_inc_in,
    // core special function register port
    input wire sfr_wr_in,
    input wire sfr_inc_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    // external data move address path
    input wire ext_move_in,
    output reg [PTR_W-1:0] ext_addr_out,
    output reg ext_addr_valid_out,
    // active pointer view for the core
    output wire [PTR_W-1:0] active_data_pointer_out,
    output wire pointer_select_bit_out
);

    // ***********************************************
    // constants
    // ***********************************************
    localparam [PTR_W-1:0] PTR_RST = `DPSEL_PTR_RESET;
    // one step for the pointer counter; wraps at the top
    localparam [PTR_W-1:0] PTR_STEP = {{(PTR_W-1){1'b0}}, 1'b1};
    localparam [7:0] CTRL_STEP = 8'h01;

    // ***********************************************
    // functions
    // ***********************************************
    function [7:0] ctrl_incremented;
        input [7:0] value;
        begin
            ctrl_incremented = value + CTRL_STEP;
        end
    endfunction

    function [PTR_W-1:0] merge_low_lanes;
        input [PTR_W-1:0] old_value;
        input [31:0] wdata;
        input [3:0] be;
        integer i;
        begin
            merge_low_lanes = old_value;
            for (i = 0; i < PTR_W; i = i + 1) begin
                if (be[i / 8]) begin
                    merge_low_lanes[i] = wdata[i];
                end
            end
        end
    endfunction

    // ***********************************************
    // reset synchroniser
    // ***********************************************
    reg rst_meta_b;
    reg rst_sync_b;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ***********************************************
    // declarations
    // ***********************************************
    reg [7:0] pointer_select_control;
    reg [7:0] next_pointer_select_control;
    reg bus_ack;
    reg bank_wr_en;
    reg bank_wr_idx;
    reg [PTR_W-1:0] bank_wr_data;
    reg [31:0] next_readdata;
    reg move_seen;
    wire [PTR_W-1:0] pointer_zero;
    wire [PTR_W-1:0] pointer_one;
    wire pointer_select_bit;
    wire [PTR_W-1:0] active_data_pointer;
    wire [9:0] bus_idx;
    wire bus_req;
    wire core_ptr_op;
    wire core_sfr_hit;
    wire core_busy;
    wire bus_accept;
    wire bus_wr;
    wire hit_ptr_zero;
    wire hit_ptr_one;
    wire hit_ptr_active;
    wire hit_status;
    wire hit_ctrl;

    // ***********************************************
    // active pointer view
    // ***********************************************
    assign pointer_select_bit = pointer_select_control[`DPSEL_SEL_BIT];
    assign active_data_pointer = pointer_select_bit ? pointer_one : pointer_zero;
    assign active_data_pointer_out = active_data_pointer;
    assign pointer_select_bit_out = pointer_select_bit;

    // ***********************************************
    // register index decode
    // ***********************************************
    assign bus_idx = avs_address_in[11:2];
    assign hit_ptr_zero = (bus_idx == `DPSEL_IDX_PTR_ZERO);
    assign hit_ptr_one = (bus_idx == `DPSEL_IDX_PTR_ONE);
    assign hit_ptr_active = (bus_idx == `DPSEL_IDX_PTR_ACTIVE);
    assign hit_status = (bus_idx == `DPSEL_IDX_STATUS);
    assign hit_ctrl = (bus_idx == `DPSEL_IDX_CTRL);

    // ***********************************************
    // bus handshake
    // ***********************************************
    assign bus_req = avs_read_in | avs_write_in;
    assign core_ptr_op = ptr_load_in | ptr_inc_in;
    assign core_sfr_hit = (sfr_wr_in | sfr_inc_in) && (sfr_addr_in == `DPSEL_SFR_CTRL_ADDR);
    // the core never waits; the bus yields to core pointer load/increment and control sfr accesses, not to moves
    assign core_busy = core_ptr_op | core_sfr_hit;
    assign bus_accept = bus_req & bus_ack & ~core_busy;
    assign bus_wr = bus_accept & avs_write_in;
    assign avs_waitrequest_out = bus_req & ~(bus_ack & ~core_busy);

    // ***********************************************
    // pointer storage
    // ***********************************************
    dpsel_ptr_bank #(
        .PTR_W(PTR_W)
    ) u_bank (
        .clk_in(clk_in),
        .rst_b_in(rst_sync_b),
        .wr_en_in(bank_wr_en),
        .wr_idx_in(bank_wr_idx),
        .wr_data_in(bank_wr_data),
        .ptr_zero_out(pointer_zero),
        .ptr_one_out(pointer_one)
    );

    // ***********************************************
    // pointer write arbitration
    // ***********************************************
    always @* begin
        bank_wr_en = 1'b0;
        bank_wr_idx = pointer_select_bit;
        bank_wr_data = active_data_pointer;
        if (ptr_load_in) begin
            bank_wr_en = 1'b1;
            bank_wr_data = ptr_load_data_in;
        end else if (ptr_inc_in) begin
            bank_wr_en = 1'b1;
            bank_wr_data = active_data_pointer + PTR_STEP;
        end else if (bus_wr) begin
            // only reached with no core op in this cycle
            if (hit_ptr_zero) begin
                bank_wr_en = 1'b1;
                bank_wr_idx = 1'b0;
                bank_wr_data = merge_low_lanes(pointer_zero, avs_writedata_in, avs_byteenable_in);
            end else if (hit_ptr_one) begin
                bank_wr_en = 1'b1;
                bank_wr_idx = 1'b1;
                bank_wr_data = merge_low_lanes(pointer_one, avs_writedata_in, avs_byteenable_in);
            end else if (hit_ptr_active) begin
                bank_wr_en = 1'b1;
                bank_wr_data = merge_low_lanes(active_data_pointer, avs_writedata_in, avs_byteenable_in);
            end
        end
    end

    // ***********************************************
    // select control register
    // ***********************************************
    always @* begin
        next_pointer_select_control = pointer_select_control;
        if (core_sfr_hit) begin
            if (sfr_inc_in) begin
                // plus one flips bit zero whatever it held
                next_pointer_select_control = ctrl_incremented(pointer_select_control);
            end else begin
                next_pointer_select_control = sfr_wdata_in;
            end
        end else if (bus_wr && hit_ctrl && avs_byteenable_in[0]) begin
            // reserved bits kept as written, which saves a mask
            next_pointer_select_control = avs_writedata_in[7:0];
        end
    end

    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pointer_select_control <= `DPSEL_CTRL_RESET;
        end else begin
            pointer_select_control <= next_pointer_select_control;
        end
    end

    // ***********************************************
    // core register read
    // ***********************************************
    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_addr_in == `DPSEL_SFR_CTRL_ADDR) begin
            // upper bits return whatever software last left there
            sfr_rdata_out <= pointer_select_control;
        end else begin
            sfr_rdata_out <= 8'h00;
        end
    end

    // ***********************************************
    // external data address path
    // ***********************************************
    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ext_addr_out <= PTR_RST;
            ext_addr_valid_out <= 1'b0;
        end else begin
            ext_addr_valid_out <= ext_move_in;
            if (ext_move_in) begin
                ext_addr_out <= active_data_pointer;
            end
        end
    end

    // sticky until reset, so software can poll it long after the move
    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            move_seen <= 1'b0;
        end else if (ext_move_in) begin
            move_seen <= 1'b1;
        end
    end

    // ***********************************************
    // avalon slave: at least one wait cycle, then accept
    // ***********************************************
    always @* begin
        next_readdata = 32'h0000_0000;
        if (hit_ptr_zero) begin
            next_readdata[PTR_W-1:0] = pointer_zero;
        end else if (hit_ptr_one) begin
            next_readdata[PTR_W-1:0] = pointer_one;
        end else if (hit_ptr_active) begin
            next_readdata[PTR_W-1:0] = active_data_pointer;
        end else if (hit_status) begin
            next_readdata[`DPSEL_STAT_SEL_BIT] = pointer_select_bit;
            next_readdata[`DPSEL_STAT_MOVE_BIT] = move_seen;
        end else if (hit_ctrl) begin
            next_readdata[7:0] = pointer_select_control;
        end
    end

    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_ack <= 1'b0;
        end else if (bus_accept) begin
            // ack drops after acceptance so each request costs two cycles at least
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req;
        end
    end

    // reloaded every waiting cycle; the last one is what the master takes
    always @(posedge clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (bus_req && !bus_accept) begin
            avs_readdata_out <= next_readdata;
        end
    end

endmodule // dpsel_top

`default_nettype wire

// ==== verification/dpsel_top_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ***************
// select checker
// ***************
module dpsel_top_chk (
    // clock, reset, bus
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // core side
    input wire logic ptr_load_in,
    input wire logic [15:0] ptr_load_data_in,
    input wire logic ptr_inc_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_inc_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic ext_move_in,
    input wire logic [15:0] ext_addr_out,
    input wire logic ext_addr_valid_out,
    input wire logic [15:0] active_data_pointer_out,
    input wire logic pointer_select_bit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic sfr_op;
    // bus writes to control also move the select, so they are excluded
    assign sfr_op = (sfr_wr_in || sfr_inc_in) && sfr_addr_in == 8'hA2;
    a_move_valid: assert property (1 |=> ext_addr_valid_out == $past(ext_move_in))
        else $error("move valid not one cycle late");
    a_move_addr: assert property (ext_move_in |=> ext_addr_out == $past(active_data_pointer_out))
        else $error("move address not active pointer");
    a_inc_toggle: assert property (sfr_op && sfr_inc_in
        |=> pointer_select_bit_out != $past(pointer_select_bit_out))
        else $error("increment did not toggle select");
    a_load_active: assert property (ptr_load_in && !sfr_op
        |=> active_data_pointer_out == $past(ptr_load_data_in))
        else $error("load missed active pointer");
    a_inc_active: assert property (ptr_inc_in && !ptr_load_in && !sfr_op
        |=> active_data_pointer_out == $past(active_data_pointer_out) + 16'h0001)
        else $error("increment missed active pointer");
    a_sel_hold: assert property (!sfr_op && !(avs_write_in && !avs_waitrequest_out)
        |=> $stable(pointer_select_bit_out))
        else $error("select moved without cause");
    a_sfr_read: assert property (sfr_addr_in == 8'hA2 && !sfr_wr_in && !sfr_inc_in && !avs_write_in
        |=> sfr_rdata_out[0] == pointer_select_bit_out)
        else $error("control read wrong");
    a_sfr_other: assert property (sfr_addr_in != 8'hA2 |=> sfr_rdata_out == 8'h00)
        else $error("other address read not zero");
    a_reset_sel: assert property (disable iff (1'h0) !rst_b_in |=> !pointer_select_bit_out)
        else $error("reset left select set");
    c_toggle: cover property (sfr_op && sfr_inc_in);
    c_move: cover property (ext_move_in && pointer_select_bit_out);
    c_load: cover property (ptr_load_in && pointer_select_bit_out);
endmodule // dpsel_top_chk
bind dpsel_top dpsel_top_chk u_chk (.clk_in, .rst_b_in, .avs_write_in, .avs_waitrequest_out, .ptr_load_in,
    .ptr_load_data_in, .ptr_inc_in, .sfr_wr_in, .sfr_inc_in, .sfr_addr_in, .sfr_rdata_out, .ext_move_in,
    .ext_addr_out, .ext_addr_valid_out, .active_data_pointer_out, .pointer_select_bit_out);
`default_nettype wire

// ==== verification/dpsel_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ***************
// core model
// ***************
module dpsel_core_model (
    // clock
    input wire logic clk_in,
    // core strobes
    output logic ld_out = 1'h0,
    output logic [15:0] ld_data_out = 16'h0000,
    output logic inc_out = 1'h0,
    output logic sfr_wr_out = 1'h0,
    output logic sfr_inc_out = 1'h0,
    output logic [7:0] sfr_addr_out = 8'h00,
    output logic [7:0] sfr_wdata_out = 8'h00,
    output logic move_out = 1'h0
);
    // one op per call, strobe high for exactly one edge
    task op(input int k, input logic [15:0] v);
        @(posedge clk_in);
        case (k)
            0: begin
                ld_data_out <= v;
                ld_out <= 1'h1;
            end
            1: inc_out <= 1'h1;
            2: begin
                sfr_addr_out <= v[7:0];
                sfr_inc_out <= 1'h1;
            end
            3: begin
                sfr_addr_out <= 8'hA2;
                sfr_wdata_out <= {7'h00, v[0]};
                sfr_wr_out <= 1'h1;
            end
            default: move_out <= 1'h1;
        endcase
        @(posedge clk_in);
        {ld_out, inc_out, sfr_wr_out, sfr_inc_out, move_out} <= 5'h00;
        // stale load data would hide a missed qualifier
        ld_data_out <= ~v;
    endtask
endmodule // dpsel_core_model
`default_nettype wire

// ==== verification/dpsel_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// ***************
// pointer select bench
// ***************
module dpsel_top_tb;
    logic clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic [11:0] addr = 12'h000;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] q;
    logic [15:0] p [2];
    logic s;
    int n_errors = 0;
    int checked = 0;
    wire [31:0] rdata;
    wire wt, ld, inc, swr, sinc, mv, eav, sel;
    wire [15:0] ldd, ea, adp;
    wire [7:0] sa, swd, srd;
    always #20 clk_in = !clk_in;
    dpsel_core_model core (.clk_in(clk_in), .ld_out(ld), .ld_data_out(ldd), .inc_out(inc), .sfr_wr_out(swr),
        .sfr_inc_out(sinc), .sfr_addr_out(sa), .sfr_wdata_out(swd), .move_out(mv));
    dpsel_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wd), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wt), .ptr_load_in(ld), .ptr_load_data_in(ldd), .ptr_inc_in(inc),
        .sfr_wr_in(swr), .sfr_inc_in(sinc), .sfr_addr_in(sa), .sfr_wdata_in(swd), .sfr_rdata_out(srd),
        .ext_move_in(mv), .ext_addr_out(ea), .ext_addr_valid_out(eav), .active_data_pointer_out(adp),
        .pointer_select_bit_out(sel));
    function logic [15:0] act();
        return p[s];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'h0};
        wd <= d;
        // a hang here is ended by the watchdog alone
        @(posedge clk_in);
        while (wt !== 1'h0) begin
            @(posedge clk_in);
        end
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task step(input int k, input logic [15:0] v);
        core.op(k, v);
        if (k == 0) p[s] = v;
        if (k == 1) p[s] = p[s] + 16'h0001;
        if (k == 2 && v[7:0] == 8'hA2) s = !s;
        if (k == 3) s = v[0];
        #1;
        chk(adp, act());
        chk(sel, s);
        if (k == 4) chk(ea, act());
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        print_verdict;
    end
    initial begin
        int k;
        s = 1'h0;
        p[0] = 16'h0000;
        p[1] = 16'h0000;
        void'($urandom(32'h4787959c));
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        bus(0, 10'h0A2, 0);
        chk(q[0], 1'h0);
        step(0, 16'hFFFF);
        step(1, 0);
        step(2, 16'h00A3);
        step(3, 16'h0001);
        step(4, 0);
        repeat (80) begin
            k = $urandom_range(4, 0);
            step(k, k == 2 ? 16'h00A2 : 16'($urandom));
        end
        // low lane only: the high byte of pointer zero must survive
        be <= 4'h1;
        bus(1, 10'h000, 32'h0000_ABCD);
        be <= 4'hF;
        p[0][7:0] = 8'hCD;
        // core increment lands while the bus write waits; the write comes later
        fork
            bus(1, 10'h002, 32'h0000_5A3C);
            begin
                @(posedge clk_in);
                core.op(1, 0);
            end
        join
        p[s] = 16'h5A3C;
        #1;
        chk(adp, act());
        for (int i = 0; i < 3; i++) begin
            bus(0, 10'(i), 0);
            chk(q, {16'h0000, i == 2 ? act() : p[i]});
        end
        bus(0, 10'h003, 0);
        chk(q, {30'h0, 1'h1, s});
        bus(1, 10'h0A2, {31'h0, !s});
        s = !s;
        #1;
        chk(adp, act());
        bus(0, 10'h010, 0);
        chk(q, 32'h0);
        rst_b_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        chk(sel, 1'h0);
        chk(adp, 16'h0000);
        print_verdict;
    end
endmodule // dpsel_top_tb
`default_nettype wire
